// File: rtl/pmpic_ctrl.sv
/*
 * Power mode and port impedance controller: idle, software and pin
 * power-down, recover mode, port impedance select, sticky serial error.
 * Assumes synchronous event inputs and an AXI4-Lite master.
 */
// Operation
// [RQ1] Software programs port impedance via io_control
// [RQ2] High-impedance select makes ports high impedance
// [RQ3] Float select floats port, else follow select
// [RQ4] Float-in-power-down floats all ports in power-down
// [RQ5] Power control holds four power-mode bits
// [RQ6] Power-down request sleeps; reset or irq lines wake
// [RQ7] Idle halts CPU; any interrupt wakes
// [RQ8] Recover off: only enabled external irqs wake
// [RQ9] Recover on: any interrupt request wakes
// [RQ10] Pin falling edge with enable enters power-down
// [RQ11] Pin rising edge wakes from pin power-down
// [RQ12] Pin and software power-down are independent
// [RQ13] Serial error flag set on overrun or framing
// [RQ14] Overrun flagged when unread character overwritten
// [RQ15] Framing flagged when stop bit missing
// [RQ16] Pending interrupt cancels power-down at once
// [RQ17] Interrupt wake clears request, services interrupt
`timescale 1ns/1ns
`default_nettype none

module pmpic_ctrl (
    input  wire logic               clk,
    input  wire logic               rst,
    input  wire logic [13:0]        s_axi_awaddr,
    input  wire logic               s_axi_awvalid,
    output logic                    s_axi_awready,
    input  wire logic [31:0]        s_axi_wdata,
    input  wire logic [3:0]         s_axi_wstrb,
    input  wire logic               s_axi_wvalid,
    output logic                    s_axi_wready,
    output logic [1:0]              s_axi_bresp,
    output logic                    s_axi_bvalid,
    input  wire logic               s_axi_bready,
    input  wire logic [13:0]        s_axi_araddr,
    input  wire logic               s_axi_arvalid,
    output logic                    s_axi_arready,
    output logic [31:0]             s_axi_rdata,
    output logic [1:0]              s_axi_rresp,
    output logic                    s_axi_rvalid,
    input  wire logic               s_axi_rready,
    input  wire pmpic_pkg::pmpic_evt_t evt,
    output pmpic_pkg::pmpic_ctl_t   ctl,
    output logic                    irq
);

    // ************************************************************
    // State
    // ************************************************************
    typedef struct packed {
        logic [7:0]              pc;
        logic [7:0]              io;
        logic [1:0]              ie;
        logic [2:0]              sts;
        logic [2:0]              msk;
        pmpic_pkg::pmpic_state_t st;
        logic                    t1;
        logic                    aw_got;
        logic                    w_got;
        logic [11:0]             aw_idx;
        logic [31:0]             wd;
        logic [3:0]              ws;
        logic                    bvalid;
        logic [1:0]              bresp;
        logic                    rvalid;
        logic [1:0]              rresp;
        logic [31:0]             rdata;
        logic                    svc;
    } pmpic_regs_t;

    pmpic_regs_t r_ff;
    pmpic_regs_t nxt_r;

    // Word index from byte address; low bits are the lane offset
    function automatic logic [11:0] idx_of(input logic [13:0] a);
        return a[13:2];
    endfunction

    function automatic logic known(input logic [11:0] i);
        return i == pmpic_pkg::PMPIC_ADDR_POWER_CONTROL || i == pmpic_pkg::PMPIC_ADDR_IO_CONTROL
            || i == pmpic_pkg::PMPIC_ADDR_IRQ_STATUS || i == pmpic_pkg::PMPIC_ADDR_IRQ_MASK
            || i == pmpic_pkg::PMPIC_ADDR_IRQ_ENABLE;
    endfunction

    logic [7:0]  rd_byte;
    logic        wake_ext;
    logic        wake_any;
    logic        do_wr;
    logic        in_pd;
    logic [11:0] ridx;

    // Handshake outputs are combinational from captured state
    assign s_axi_awready = !r_ff.aw_got && !r_ff.bvalid;
    assign s_axi_wready  = !r_ff.w_got && !r_ff.bvalid;
    assign s_axi_arready = !r_ff.rvalid;
    assign s_axi_bvalid  = r_ff.bvalid;
    assign s_axi_bresp   = r_ff.bresp;
    assign s_axi_rvalid  = r_ff.rvalid;
    assign s_axi_rresp   = r_ff.rresp;
    assign s_axi_rdata   = r_ff.rdata;
    assign irq           = |(r_ff.sts & r_ff.msk);
    assign ridx          = idx_of(s_axi_araddr);

    // [RQ12] independent power-down paths
    assign in_pd = r_ff.st == pmpic_pkg::PMPIC_SW_PD || r_ff.st == pmpic_pkg::PMPIC_PIN_PD;

    // [RQ8] enabled external lines wake
    assign wake_ext = (evt.ext_irq_line_zero && r_ff.ie[pmpic_pkg::IE_IRQ0])
                   || (evt.ext_irq_line_one && r_ff.ie[pmpic_pkg::IE_IRQ1]);
    // [RQ9] recover lets any request wake
    assign wake_any = wake_ext || (r_ff.pc[pmpic_pkg::PC_RECOVER_EN]
                   && (evt.any_irq_request || evt.ext_irq_line_zero || evt.ext_irq_line_one));

    // Read mux
    always_comb begin
        case (ridx)
            pmpic_pkg::PMPIC_ADDR_POWER_CONTROL: rd_byte = r_ff.pc;
            pmpic_pkg::PMPIC_ADDR_IO_CONTROL:    rd_byte = r_ff.io;
            pmpic_pkg::PMPIC_ADDR_IRQ_STATUS:    rd_byte = {5'h00, r_ff.sts};
            pmpic_pkg::PMPIC_ADDR_IRQ_MASK:      rd_byte = {5'h00, r_ff.msk};
            pmpic_pkg::PMPIC_ADDR_IRQ_ENABLE:    rd_byte = {6'h00, r_ff.ie};
            default:                             rd_byte = 8'h00;
        endcase
    end

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb begin
        nxt_r     = r_ff;
        nxt_r.t1  = evt.timer_one_pin;
        nxt_r.svc = 1'b0;
        do_wr     = 1'b0;

        // Capture write address and data in either order
        if (s_axi_awvalid && s_axi_awready) begin
            nxt_r.aw_got = 1'b1;
            nxt_r.aw_idx = idx_of(s_axi_awaddr);
        end
        if (s_axi_wvalid && s_axi_wready) begin
            nxt_r.w_got = 1'b1;
            nxt_r.wd    = s_axi_wdata;
            nxt_r.ws    = s_axi_wstrb;
        end
        if (r_ff.aw_got && r_ff.w_got) begin
            do_wr        = r_ff.ws[0] && known(r_ff.aw_idx);
            nxt_r.aw_got = 1'b0;
            nxt_r.w_got  = 1'b0;
            nxt_r.bvalid = 1'b1;
            nxt_r.bresp  = known(r_ff.aw_idx) ? pmpic_pkg::AXI_OKAY : pmpic_pkg::AXI_SLVERR;
        end
        if (r_ff.bvalid && s_axi_bready) begin
            nxt_r.bvalid = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            nxt_r.rvalid = 1'b1;
            nxt_r.rdata  = {24'h000000, rd_byte};
            nxt_r.rresp  = known(ridx) ? pmpic_pkg::AXI_OKAY : pmpic_pkg::AXI_SLVERR;
        end
        if (r_ff.rvalid && s_axi_rready) begin
            nxt_r.rvalid = 1'b0;
        end

        // Register writes; write-one-to-clear on status
        if (do_wr) begin
            case (r_ff.aw_idx)
                // [RQ5] power control layout
                pmpic_pkg::PMPIC_ADDR_POWER_CONTROL:
                    nxt_r.pc = r_ff.wd[7:0] & pmpic_pkg::PC_WRITE_MASK;
                // [RQ1] impedance programming
                pmpic_pkg::PMPIC_ADDR_IO_CONTROL:
                    nxt_r.io = (r_ff.io & ~pmpic_pkg::IO_WRITE_MASK)
                             | (r_ff.wd[7:0] & pmpic_pkg::IO_WRITE_MASK);
                pmpic_pkg::PMPIC_ADDR_IRQ_STATUS:
                    nxt_r.sts = r_ff.sts & ~r_ff.wd[2:0];
                pmpic_pkg::PMPIC_ADDR_IRQ_MASK:
                    nxt_r.msk = r_ff.wd[2:0] & pmpic_pkg::EV_MASK;
                pmpic_pkg::PMPIC_ADDR_IRQ_ENABLE:
                    nxt_r.ie = r_ff.wd[1:0];
                default: ;
            endcase
            // Serial error flag clears by writing a one; set still wins below
            if (r_ff.aw_idx == pmpic_pkg::PMPIC_ADDR_IO_CONTROL
                && r_ff.wd[pmpic_pkg::IO_SERIAL_ERR]) begin
                nxt_r.io[pmpic_pkg::IO_SERIAL_ERR] = 1'b0;
            end
        end

        // [RQ13] sticky serial error, set wins
        // [RQ14] overrun and [RQ15] framing
        if (evt.rx_overrun || evt.rx_frame_err) begin
            nxt_r.io[pmpic_pkg::IO_SERIAL_ERR] = 1'b1;
            nxt_r.sts[pmpic_pkg::EV_SERIAL]    = 1'b1;
        end

        // Power state machine
        case (r_ff.st)
            pmpic_pkg::PMPIC_RUN: begin
                // [RQ10] pin falling edge enters power-down
                if (r_ff.pc[pmpic_pkg::PC_PIN_SLEEP_EN] && r_ff.t1 && !evt.timer_one_pin) begin
                    nxt_r.st = pmpic_pkg::PMPIC_PIN_PD;
                    nxt_r.sts[pmpic_pkg::EV_PD] = 1'b1;
                end else if (r_ff.pc[pmpic_pkg::PC_POWER_DOWN]) begin
                    // [RQ16] pending interrupt cancels at once
                    if (wake_any) begin
                        nxt_r.pc[pmpic_pkg::PC_POWER_DOWN] = 1'b0;
                        nxt_r.svc = 1'b1;
                    end else begin
                        // [RQ6] software power-down entry
                        nxt_r.st = pmpic_pkg::PMPIC_SW_PD;
                        nxt_r.sts[pmpic_pkg::EV_PD] = 1'b1;
                    end
                end else if (r_ff.pc[pmpic_pkg::PC_SLEEP]) begin
                    // [RQ7] idle entry
                    nxt_r.st = pmpic_pkg::PMPIC_IDLE;
                end
            end
            pmpic_pkg::PMPIC_IDLE: begin
                // [RQ7] any interrupt request ends idle
                if (evt.any_irq_request || wake_any) begin
                    nxt_r.st = pmpic_pkg::PMPIC_RUN;
                    // [RQ17] clear request, service
                    nxt_r.pc[pmpic_pkg::PC_SLEEP] = 1'b0;
                    nxt_r.svc = 1'b1;
                    nxt_r.sts[pmpic_pkg::EV_WAKE] = 1'b1;
                end
            end
            pmpic_pkg::PMPIC_SW_PD: begin
                // [RQ6] external lines cancel power-down
                if (wake_any) begin
                    nxt_r.st = pmpic_pkg::PMPIC_RUN;
                    // [RQ17] clear request, service
                    nxt_r.pc[pmpic_pkg::PC_POWER_DOWN] = 1'b0;
                    nxt_r.svc = 1'b1;
                    nxt_r.sts[pmpic_pkg::EV_WAKE] = 1'b1;
                end
            end
            pmpic_pkg::PMPIC_PIN_PD: begin
                // [RQ11] pin rising edge wakes
                if (!r_ff.t1 && evt.timer_one_pin) begin
                    nxt_r.st = pmpic_pkg::PMPIC_RUN;
                    nxt_r.sts[pmpic_pkg::EV_WAKE] = 1'b1;
                end
            end
            default: nxt_r.st = pmpic_pkg::PMPIC_RUN;
        endcase
    end

    // Register the whole state; pin history resets high so no false edge
    always_ff @(posedge clk) begin
        if (rst) begin
            r_ff    <= '0;
            r_ff.pc <= pmpic_pkg::PMPIC_RESET_BYTE;
            r_ff.io <= pmpic_pkg::PMPIC_RESET_BYTE;
            r_ff.st <= pmpic_pkg::PMPIC_RUN;
            r_ff.t1 <= 1'b1;
        end else begin
            r_ff <= nxt_r;
        end
    end

    // ************************************************************
    // Port impedance
    // ************************************************************
    // [RQ2] [RQ3] [RQ4] impedance select per port
    function automatic pmpic_pkg::pmpic_imp_t imp_of(input logic fl, input logic hz,
                                                    input logic pdf);
        if (fl || pdf) return pmpic_pkg::PMPIC_IMP_FLOAT;
        return hz ? pmpic_pkg::PMPIC_IMP_HIGH : pmpic_pkg::PMPIC_IMP_NORMAL;
    endfunction

    logic pd_float;
    assign pd_float = in_pd && r_ff.io[pmpic_pkg::IO_FLOAT_IN_PD];

    // Core controls; oscillator stops only in power-down
    always_comb begin
        ctl.cpu_halt      = r_ff.st != pmpic_pkg::PMPIC_RUN;
        ctl.periph_clk_en = !in_pd;
        ctl.osc_en        = !in_pd;
        ctl.irq_service   = r_ff.svc;
        ctl.port1_imp = imp_of(r_ff.io[pmpic_pkg::IO_PORT1_FLOAT],
                               r_ff.io[pmpic_pkg::IO_HIGH_Z_SEL], pd_float);
        ctl.port2_imp = imp_of(r_ff.io[pmpic_pkg::IO_PORT2_FLOAT],
                               r_ff.io[pmpic_pkg::IO_HIGH_Z_SEL], pd_float);
        ctl.port3_imp = imp_of(r_ff.io[pmpic_pkg::IO_PORT3_FLOAT],
                               r_ff.io[pmpic_pkg::IO_HIGH_Z_SEL], pd_float);
    end

    // ************************************************************
    // Assertions
    // ************************************************************
    property p_float_pd;
        @(posedge clk) disable iff (rst)
        (in_pd && r_ff.io[pmpic_pkg::IO_FLOAT_IN_PD])
            |-> ctl.port1_imp == pmpic_pkg::PMPIC_IMP_FLOAT;
    endproperty
    a_float_pd: assert property (p_float_pd) else $error("ports not floating in sleep"); // [RQ4]

    property p_hz;
        @(posedge clk) disable iff (rst)
        (!pd_float && !r_ff.io[pmpic_pkg::IO_PORT2_FLOAT] && r_ff.io[pmpic_pkg::IO_HIGH_Z_SEL])
            |-> ctl.port2_imp == pmpic_pkg::PMPIC_IMP_HIGH;
    endproperty
    a_hz: assert property (p_hz) else $error("high impedance not applied"); // [RQ2]

    property p_pin_enter;
        @(posedge clk) disable iff (rst)
        (r_ff.st == pmpic_pkg::PMPIC_RUN && r_ff.pc[pmpic_pkg::PC_PIN_SLEEP_EN]
            && r_ff.t1 && !evt.timer_one_pin) |=> r_ff.st == pmpic_pkg::PMPIC_PIN_PD;
    endproperty
    a_pin_enter: assert property (p_pin_enter) else $error("pin sleep not entered"); // [RQ10]

    property p_pin_wake;
        @(posedge clk) disable iff (rst)
        (r_ff.st == pmpic_pkg::PMPIC_PIN_PD && !r_ff.t1 && evt.timer_one_pin)
            |=> r_ff.st == pmpic_pkg::PMPIC_RUN && ctl.osc_en;
    endproperty
    a_pin_wake: assert property (p_pin_wake) else $error("pin wake failed"); // [RQ11]

    property p_serial_error_flag;
        @(posedge clk) disable iff (rst)
        (evt.rx_overrun || evt.rx_frame_err) |=> r_ff.io[pmpic_pkg::IO_SERIAL_ERR];
    endproperty
    a_serial_error_flag: assert property (p_serial_error_flag) else $error("serial error not flagged"); // [RQ13]

    property p_sw_wake;
        @(posedge clk) disable iff (rst)
        (r_ff.st == pmpic_pkg::PMPIC_SW_PD && wake_any)
            |=> r_ff.st == pmpic_pkg::PMPIC_RUN && ctl.irq_service
                && !r_ff.pc[pmpic_pkg::PC_POWER_DOWN];
    endproperty
    a_sw_wake: assert property (p_sw_wake) else $error("power-down wake failed"); // [RQ17]

    property p_no_wake;
        @(posedge clk) disable iff (rst)
        (r_ff.st == pmpic_pkg::PMPIC_SW_PD && !r_ff.pc[pmpic_pkg::PC_RECOVER_EN]
            && !(evt.ext_irq_line_zero && r_ff.ie[pmpic_pkg::IE_IRQ0])
            && !(evt.ext_irq_line_one && r_ff.ie[pmpic_pkg::IE_IRQ1]))
            |=> r_ff.st == pmpic_pkg::PMPIC_SW_PD;
    endproperty
    a_no_wake: assert property (p_no_wake) else $error("disabled irq woke device"); // [RQ8]

    property p_pending;
        @(posedge clk) disable iff (rst)
        (r_ff.st == pmpic_pkg::PMPIC_RUN && r_ff.pc[pmpic_pkg::PC_POWER_DOWN]
            && r_ff.pc[pmpic_pkg::PC_RECOVER_EN] && evt.any_irq_request
            && !(r_ff.pc[pmpic_pkg::PC_PIN_SLEEP_EN] && r_ff.t1 && !evt.timer_one_pin))
            |=> r_ff.st == pmpic_pkg::PMPIC_RUN && ctl.irq_service
                && !r_ff.pc[pmpic_pkg::PC_POWER_DOWN];
    endproperty
    a_pending: assert property (p_pending) else $error("pending irq did not cancel"); // [RQ16]

    property p_idle_wake;
        @(posedge clk) disable iff (rst)
        (r_ff.st == pmpic_pkg::PMPIC_IDLE && evt.any_irq_request)
            |=> r_ff.st == pmpic_pkg::PMPIC_RUN && !r_ff.pc[pmpic_pkg::PC_SLEEP];
    endproperty
    a_idle_wake: assert property (p_idle_wake) else $error("idle not cancelled"); // [RQ7]

endmodule

`default_nettype wire

// File: shared/pmpic_pkg.sv
/*
 * Package for the power mode and port impedance controller: register
 * word indices, field positions, reset values and carrier structs.
 * Assumes a 32-bit AXI4-Lite register bus and a single 250 MHz clock.
 */
package pmpic_pkg;

    // ************************************************************
    // Register map
    // ************************************************************
    localparam logic [11:0] PMPIC_ADDR_POWER_CONTROL = 12'h087; // Index, byte addr = 4x
    localparam logic [11:0] PMPIC_ADDR_IO_CONTROL    = 12'h0F8;
    localparam logic [11:0] PMPIC_ADDR_IRQ_STATUS    = 12'h100;
    localparam logic [11:0] PMPIC_ADDR_IRQ_MASK      = 12'h101;
    localparam logic [11:0] PMPIC_ADDR_IRQ_ENABLE    = 12'h102;

    // Power control fields
    localparam int PC_BAUD_DOUBLER  = 7;
    localparam int PC_PIN_SLEEP_EN  = 6;
    localparam int PC_RECOVER_EN    = 5;
    localparam int PC_GEN_FLAG_ONE  = 3;
    localparam int PC_GEN_FLAG_ZERO = 2;
    localparam int PC_POWER_DOWN    = 1;
    localparam int PC_SLEEP         = 0;
    localparam logic [7:0] PC_WRITE_MASK = 8'hEF; // Bit 4 reserved

    // I/O control fields
    localparam int IO_SERIAL_ERR    = 5;
    localparam int IO_HIGH_Z_SEL    = 4;
    localparam int IO_PORT3_FLOAT   = 3;
    localparam int IO_PORT2_FLOAT   = 2;
    localparam int IO_PORT1_FLOAT   = 1;
    localparam int IO_FLOAT_IN_PD   = 0;
    localparam logic [7:0] IO_WRITE_MASK = 8'h1F;

    // Interrupt enable fields and status events
    localparam int IE_IRQ0 = 0;
    localparam int IE_IRQ1 = 1;
    localparam int EV_SERIAL = 0;
    localparam int EV_WAKE   = 1;
    localparam int EV_PD     = 2;
    localparam logic [2:0] EV_MASK = 3'h7;

    localparam logic [7:0] PMPIC_RESET_BYTE = 8'h00;
    localparam logic [1:0] AXI_OKAY   = 2'h0;
    localparam logic [1:0] AXI_SLVERR = 2'h2;

    // Port impedance encoding
    typedef enum logic [1:0] {
        PMPIC_IMP_NORMAL = 2'h0,
        PMPIC_IMP_HIGH   = 2'h1,
        PMPIC_IMP_FLOAT  = 2'h2
    } pmpic_imp_t;

    // Power state, one-hot
    typedef enum logic [3:0] {
        PMPIC_RUN      = 4'h1,
        PMPIC_IDLE     = 4'h2,
        PMPIC_SW_PD    = 4'h4,
        PMPIC_PIN_PD   = 4'h8
    } pmpic_state_t;

    // Wake and sleep sources and serial error strobes from the core
    typedef struct packed {
        logic ext_irq_line_zero;
        logic ext_irq_line_one;
        logic any_irq_request;
        logic timer_one_pin;
        logic rx_overrun;
        logic rx_frame_err;
    } pmpic_evt_t;

    // Core-facing controls
    typedef struct packed {
        logic       cpu_halt;
        logic       periph_clk_en;
        logic       osc_en;
        logic       irq_service;
        pmpic_imp_t port1_imp;
        pmpic_imp_t port2_imp;
        pmpic_imp_t port3_imp;
    } pmpic_ctl_t;

endpackage

// File: testbench/pmpic_partner.sv
/* Partner model: external interrupt lines, core interrupt request,
 * timer-one pin and serial receiver error strobes.
 * Assumes the bench changes cmd just after a rising clock edge. */
`timescale 1ns/1ns
`default_nettype none
module pmpic_partner (
    input  wire logic              clk,
    input  wire logic              rst,
    input  wire logic [5:0]        cmd,
    output pmpic_pkg::pmpic_evt_t  evt
);
    // ****************************************
    // Event drivers
    // ****************************************
    // lines and pin edges
    // Pin idles high so only a real falling edge starts power-down
    always_ff @(posedge clk) begin
        if (rst) begin
            evt <= pmpic_pkg::pmpic_evt_t'(6'h04);
        end else begin
            evt <= pmpic_pkg::pmpic_evt_t'(cmd);
        end
    end
endmodule
`default_nettype wire

// File: testbench/power_mode_and_port_impedance_ctrl_test.sv
/* Testbench for the power mode and port impedance controller.
 * Assumes pmpic_ctrl, pmpic_partner and the package are compiled first. */
`timescale 1ns/1ns
`default_nettype none
module power_mode_and_port_impedance_ctrl_test;
    // ****************************************
    // Signals and instances
    // ****************************************
    localparam logic [13:0] A_PC = {pmpic_pkg::PMPIC_ADDR_POWER_CONTROL, 2'h0};
    localparam logic [13:0] A_IO = {pmpic_pkg::PMPIC_ADDR_IO_CONTROL, 2'h0};
    localparam logic [13:0] A_ST = {pmpic_pkg::PMPIC_ADDR_IRQ_STATUS, 2'h0};
    localparam logic [13:0] A_MK = {pmpic_pkg::PMPIC_ADDR_IRQ_MASK, 2'h0};
    localparam logic [13:0] A_IE = {pmpic_pkg::PMPIC_ADDR_IRQ_ENABLE, 2'h0};
    typedef struct packed {logic [7:0] io; logic [5:0] imp;} pmpic_row_t;
    pmpic_row_t rows [6] = '{'{8'h00, 6'h00}, '{8'h10, 6'h15}, '{8'h12, 6'h25},
                             '{8'h04, 6'h08}, '{8'h08, 6'h02}, '{8'h1E, 6'h2A}};
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [13:0] awaddr = '0, araddr = '0;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic awready, wready, bvalid, arready, rvalid, irq;
    logic [31:0] wdata = '0, rdata, rd_data;
    logic [1:0] bresp, rresp, rd_resp;
    logic [5:0] cmd = 6'h04;
    pmpic_pkg::pmpic_evt_t evt;
    pmpic_pkg::pmpic_ctl_t ctl;
    int fail_count = 0, checks_done = 0, svc_cnt = 0, s0;

    pmpic_ctrl dut (.clk(clk), .rst(rst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .evt(evt), .ctl(ctl), .irq(irq));
    pmpic_partner partner (.clk(clk), .rst(rst), .cmd(cmd), .evt(evt));

    // Clock and service pulse counter
    always #2 clk = ~clk;
    always @(posedge clk) if (ctl.irq_service === 1'b1) svc_cnt <= svc_cnt + 1;

    // ****************************************
    // Tasks
    // ****************************************
    task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string m);
        checks_done++;
        if (got !== exp) begin
            $display("wrong value at %0t: %s got %h expected %h", $time, m, got, exp);
            fail_count++;
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge clk);
    endtask
    // Bounded waits so a silent slave ends as a mismatch, not a hang
    task automatic wr(input logic [13:0] a, input logic [7:0] d);
        int n;
        n = 0;
        awaddr <= a;
        wdata <= {24'h0, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge clk);
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
            n++;
        end while (bvalid !== 1'b1 && n < 40);
        bready <= 1'b0;
        chk({bvalid, bresp}, {1'b1, pmpic_pkg::AXI_OKAY}, "write answer");
        @(posedge clk);
    endtask
    task automatic rd(input logic [13:0] a);
        int n;
        n = 0;
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge clk);
            if (arready === 1'b1) arvalid <= 1'b0;
            n++;
        end while (rvalid !== 1'b1 && n < 40);
        rd_data = rdata;
        rd_resp = rresp;
        rready <= 1'b0;
        chk(rvalid, 1, "read answer");
        @(posedge clk);
    endtask
    task automatic report_and_stop;
        $display("checks %0d errors %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // ****************************************
    // Sequence and watchdog
    // ****************************************
    initial begin
        step(12);
        rst <= 1'b0;
        step(1);
        rd(A_PC);
        chk(rd_data, 0, "pc reset");
        foreach (rows[i]) begin
            wr(A_IO, rows[i].io);
            step(1);
            chk({ctl.port1_imp, ctl.port2_imp, ctl.port3_imp}, rows[i].imp, "imp");
            rd(A_IO);
            chk(rd_data, rows[i].io, "io readback");
        end
        wr(A_PC, 8'hFC);
        rd(A_PC);
        chk(rd_data, 8'hEC, "pc fields");
        wr(A_PC, 8'h00);
        rd(14'h0010);
        chk({rd_resp, rd_data}, {pmpic_pkg::AXI_SLVERR, 32'h0}, "unmapped");
        wr(A_IO, 8'h01);
        wr(A_IE, 8'h01);
        wr(A_PC, 8'h02);
        step(3);
        chk({ctl.osc_en, ctl.periph_clk_en}, 0, "pd clocks");
        chk({ctl.port1_imp, ctl.port2_imp, ctl.port3_imp}, 6'h2A, "pd float");
        cmd[4] <= 1'b1;
        step(3);
        chk(ctl.osc_en, 0, "line one off");
        cmd[5] <= 1'b1;
        step(3);
        chk(ctl.osc_en, 1, "line zero wake");
        cmd[5:4] <= 2'h0;
        rd(A_PC);
        chk(rd_data, 0, "pd cleared");
        s0 = svc_cnt;
        wr(A_PC, 8'h01);
        step(2);
        chk({ctl.cpu_halt, ctl.periph_clk_en, ctl.osc_en}, 3'h7, "idle");
        cmd[3] <= 1'b1;
        step(2);
        cmd[3] <= 1'b0;
        step(2);
        chk({ctl.cpu_halt, svc_cnt - s0}, 33'h1, "idle wake");
        rd(A_PC);
        chk(rd_data, 0, "idle cleared");
        cmd[3] <= 1'b1;
        step(2);
        s0 = svc_cnt;
        wr(A_PC, 8'h22);
        step(3);
        chk({ctl.osc_en, svc_cnt - s0}, 33'h100000001, "cancel");
        cmd[3] <= 1'b0;
        rd(A_PC);
        chk(rd_data, 8'h20, "cancel clears");
        wr(A_IE, 8'h00);
        wr(A_PC, 8'h22);
        step(3);
        chk(ctl.osc_en, 0, "rec pd");
        cmd[4] <= 1'b1;
        step(3);
        chk(ctl.osc_en, 1, "rec wake");
        cmd[4] <= 1'b0;
        wr(A_PC, 8'h40);
        cmd[2] <= 1'b0;
        step(3);
        chk({ctl.osc_en, ctl.cpu_halt, ctl.port1_imp}, 4'h6, "pin pd");
        cmd[2] <= 1'b1;
        step(3);
        chk(ctl.osc_en, 1, "pin wake");
        rd(A_PC);
        chk(rd_data, 8'h40, "pin bits");
        wr(A_PC, 8'h00);
        wr(A_MK, 8'h01);
        wr(A_ST, 8'h07);
        cmd[1] <= 1'b1;
        step(1);
        cmd[1] <= 1'b0;
        step(3);
        chk(irq, 1, "irq set");
        rd(A_IO);
        chk(rd_data, 8'h21, "overrun");
        wr(A_IO, 8'h20);
        wr(A_ST, 8'h01);
        rd(A_IO);
        chk({irq, rd_data}, 0, "clr");
        cmd[0] <= 1'b1;
        step(1);
        cmd[0] <= 1'b0;
        step(3);
        rd(A_IO);
        chk({irq, rd_data}, 33'h100000020, "framing");
        wr(A_MK, 8'h00);
        step(1);
        chk(irq, 0, "masked");
        // Reset in mid-run leaves power-down and clears the registers
        wr(A_PC, 8'h02);
        step(2);
        chk(ctl.osc_en, 0, "pd before reset");
        rst <= 1'b1;
        step(2);
        rst <= 1'b0;
        step(1);
        chk({ctl.osc_en, ctl.cpu_halt, irq}, 3'h4, "reset wakes");
        rd(A_IO);
        chk(rd_data, 0, "io reset");
        report_and_stop;
    end
    initial begin
        repeat (20000) @(posedge clk);
        fail_count++;
        report_and_stop;
    end
endmodule
`default_nettype wire
